// ===== shared/ctsc_pkg.sv
/*
 * constants and carrier types of the conversion timing and sync control.
 * assumes one 100 MHz core clock; every rate is derived from it.
 */
`default_nettype none
package ctsc_pkg;

	// ************************************************************
	// rates
	// ************************************************************
	localparam int CLK_MHZ = 100;
	localparam int REF_DIV = 256;
	localparam int MOD_DIV = 512;
	localparam int REF_W = 8;
	localparam int MOD_W = 9;

	// ************************************************************
	// filter notch and settling
	// ************************************************************
	localparam int NOTCH_W = 12;
	localparam logic [NOTCH_W-1:0] NOTCH_RST = 12'h080;
	localparam int SETTLE_W = 4;
	localparam logic [SETTLE_W-1:0] SETTLE_UPDATES = 4'h3;
	localparam logic [SETTLE_W-1:0] CAL_UPDATES = 4'h6;

	// ************************************************************
	// result
	// ************************************************************
	localparam int DATA_W = 24;
	localparam logic [DATA_W-1:0] RESULT_RST = 24'h000000;

	typedef enum logic [2:0] {
		CTSC_HOLD = 3'b001,
		CTSC_SETTLE = 3'b010,
		CTSC_RUN = 3'b100
	} ctsc_mode_t;

	typedef struct packed {
		logic syncN;
		logic calCmd;
		logic [NOTCH_W-1:0] notchCode;
	} ctsc_ctrl_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic ready;
	} ctsc_result_t;

endpackage
`default_nettype wire

// ===== verif/ctsc_host.sv
/* host model: drives sync, calibration pulse and read acknowledge.
 * assumes bench requests change at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module ctsc_host (
	input wire logic core_clk,
	input wire logic doSync,
	input wire logic doCal,
	input wire logic [11:0] notch,
	input wire logic ready,
	output var ctsc_pkg::ctsc_ctrl_t ctrl,
	output logic rdAck
);
	initial ctrl = '{1'b1, 1'b0, 12'h001};
	initial rdAck = 0;
	always @(negedge core_clk) begin
		ctrl.syncN <= !doSync;
		ctrl.calCmd <= doCal;
		ctrl.notchCode <= notch;
		rdAck <= ready && !rdAck && $urandom_range(0, 3) == 0;
	end
endmodule
`default_nettype wire

// ===== verif/ctsc_timing_bench.sv
/* self-checking bench of ctsc_timing driven by the host model.
 * assumes the checker is bound to the design. */
`timescale 1ns/1ps
`default_nettype none
module ctsc_timing_bench;
	logic core_clk = 0, srst = 1, doSync = 0, doCal = 0;
	logic rdAck, refSampleEn, modSampleEn, updateEn, filterRst, calBusy;
	logic [11:0] notch = 12'h001;
	logic [23:0] filtData = 0, d;
	logic [11:0] nt [3] = '{12'h001, 12'h000, 12'h002};
	ctsc_pkg::ctsc_ctrl_t ctrl;
	ctsc_pkg::ctsc_mode_t mode;
	ctsc_pkg::ctsc_result_t result;
	int errCount = 0, nTests = 0, cyc = 0, t, tp, t0;
	wire logic [2:0] ev = {updateEn, modSampleEn, refSampleEn};
	ctsc_timing dut (.core_clk, .srst, .ctrl, .filtData, .rdAck, .refSampleEn,
		.modSampleEn, .updateEn, .filterRst, .calBusy, .mode, .result);
	ctsc_host host (.core_clk, .doSync, .doCal, .notch, .ready(result.ready),
		.ctrl, .rdAck);
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	always @(negedge core_clk) filtData <= 24'($urandom);
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			errCount++;
			summarize();
		end
	end
	function automatic int period(logic [11:0] n);
		return ctsc_pkg::MOD_DIV * ((n == 0) ? 1 : int'(n));
	endfunction
	// cycles from a restart to the first update after k settling updates
	function automatic int span(int k, logic [11:0] n);
		return (k + 1) * period(n) - 1;
	endfunction
	task automatic check(logic [31:0] got, logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			errCount++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic waitOn(int s);
		int k = 0;
		do begin
			@(negedge core_clk);
			k++;
		end while (ev[s] !== 1'b1 && k < 9000);
		t = cyc;
	endtask
	task automatic pulse(bit cal);
		@(negedge core_clk);
		doSync <= !cal;
		doCal <= cal;
		@(negedge core_clk);
		doSync <= 0;
		doCal <= 0;
		@(posedge core_clk) #1;
	endtask
	task automatic summarize();
		$display("tests %0d errors %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h00B7347C));
		repeat (2) @(posedge core_clk);
		@(negedge core_clk) srst <= 0;
		foreach (nt[i]) begin
			notch <= nt[i];
			pulse(0);
			check({filterRst, mode}, {1'b1, ctsc_pkg::CTSC_HOLD});
			t0 = cyc;
			waitOn(2);
			check(t - t0, span(ctsc_pkg::SETTLE_UPDATES, nt[i]));
			repeat (3) begin
				tp = t;
				#1 d = filtData;
				@(posedge core_clk) #1;
				check(result, {d, 1'b1});
				waitOn(2);
				check(t - tp, period(nt[i]));
			end
		end
		pulse(1);
		check({calBusy, filterRst, result.ready}, 3'b110);
		t0 = cyc;
		waitOn(2);
		check(t - t0, span(ctsc_pkg::CAL_UPDATES, nt[2]));
		check(calBusy, 0);
		pulse(0);
		waitOn(2);
		check(mode, ctsc_pkg::CTSC_RUN);
		waitOn(0);
		tp = t;
		waitOn(0);
		check(t - tp, 256);
		waitOn(1);
		tp = t;
		waitOn(1);
		check(t - tp, 512);
		summarize();
	end
endmodule
`default_nettype wire

// ===== verif/ctsc_timing_properties.sv
/* port assertions of the timing and sync control.
 * assumes it is bound to each ctsc_timing instance. */
`timescale 1ns/1ps
`default_nettype none
module ctsc_timing_properties (
	input wire logic core_clk,
	input wire logic srst,
	input wire ctsc_pkg::ctsc_ctrl_t ctrl,
	input wire logic [23:0] filtData,
	input wire logic rdAck,
	input wire logic refSampleEn,
	input wire logic modSampleEn,
	input wire logic updateEn,
	input wire logic filterRst,
	input wire ctsc_pkg::ctsc_mode_t mode,
	input wire ctsc_pkg::ctsc_result_t result
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);
	sequence s_restart;
		$fell(ctrl.syncN) || ctrl.calCmd;
	endsequence
	sequence s_rstPulse;
		filterRst ##1 !filterRst;
	endsequence
	property p_restart;
		s_restart ##1 (!$fell(ctrl.syncN) && !ctrl.calCmd) |-> s_rstPulse;
	endproperty
	property p_rstEach;
		s_restart |=> filterRst;
	endproperty
	property p_rstOnly;
		!$fell(ctrl.syncN) && !ctrl.calCmd |=> !filterRst;
	endproperty
	property p_ref;
		disable iff (srst || filterRst || !ctrl.syncN)
		refSampleEn |-> ##256 refSampleEn;
	endproperty
	property p_mod;
		disable iff (srst || filterRst || !ctrl.syncN)
		modSampleEn |-> ##[512:512] modSampleEn;
	endproperty
	property p_load;
		updateEn |=> result.ready && result.data == $past(filtData);
	endproperty
	property p_run;
		updateEn |-> mode == ctsc_pkg::CTSC_RUN &&
			$past(mode) == ctsc_pkg::CTSC_RUN;
	endproperty
	property p_ack;
		rdAck && !updateEn |=> !result.ready;
	endproperty
	property p_drop;
		$fell(result.ready) |-> $past(rdAck) || filterRst;
	endproperty
	property p_hold;
		!ctrl.syncN |=> mode == ctsc_pkg::CTSC_HOLD;
	endproperty
	a_restart: assert property (p_restart) else $error("no reset");
	a_rstEach: assert property (p_rstEach) else $error("no reset");
	a_rstOnly: assert property (p_rstOnly) else $error("stray reset");
	a_ref: assert property (p_ref) else $error("ref gap");
	a_mod: assert property (p_mod) else $error("mod gap");
	a_load: assert property (p_load) else $error("no load");
	a_run: assert property (p_run) else $error("early update");
	a_ack: assert property (p_ack) else $error("ready kept");
	a_drop: assert property (p_drop) else $error("ready lost");
	a_hold: assert property (p_hold) else $error("no hold");
endmodule
bind ctsc_timing ctsc_timing_properties chk (.core_clk, .srst, .ctrl,
	.filtData, .rdAck, .refSampleEn, .modSampleEn, .updateEn, .filterRst,
	.mode, .result);
`default_nettype wire

// ===== verilog/ctsc_div.sv
/*
 * enable-driven counter that pulses on its last count and restarts.
 * assumes clr and en are synchronous to clk; clr wins over counting.
 */
`timescale 1ns/1ps
`default_nettype none
module ctsc_div #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic clr,
	input wire logic en,
	input wire logic [W-1:0] lastCnt,
	output logic tick
);

	typedef struct packed {
		logic [W-1:0] cnt;
	} ctsc_div_state_t;

	ctsc_div_state_t st_r;
	ctsc_div_state_t st_nxt;

	assign tick = en && !clr && (st_r.cnt >= lastCnt);

	always_comb begin
		st_nxt = st_r;
		if (clr) begin
			st_nxt.cnt = '0;
		end else if (tick) begin
			st_nxt.cnt = '0;
		end else if (en) begin
			st_nxt.cnt = st_r.cnt + W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule
`default_nettype wire

// ===== verilog/ctsc_timing.sv
/*
 * conversion timing and sync control: free-running sample rates, output
 * update at the notch rate, filter reset on sync or calibration.
 * assumes the filter datapath supplies filtData and obeys filterRst;
 * all inputs are synchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module ctsc_timing (
	input wire logic core_clk,
	input wire logic srst,
	input wire ctsc_pkg::ctsc_ctrl_t ctrl,
	input wire logic [ctsc_pkg::DATA_W-1:0] filtData,
	input wire logic rdAck,
	output logic refSampleEn,
	output logic modSampleEn,
	output logic updateEn,
	output logic filterRst,
	output logic calBusy,
	output var ctsc_pkg::ctsc_mode_t mode,
	output var ctsc_pkg::ctsc_result_t result
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		ctsc_pkg::ctsc_mode_t mode;
		logic syncPrev;
		logic filterRst;
		logic calBusy;
		logic [ctsc_pkg::SETTLE_W-1:0] settleLeft;
		ctsc_pkg::ctsc_result_t result;
	} ctsc_state_t;

	ctsc_state_t st_r;
	ctsc_state_t st_nxt;

	logic syncFall;
	logic restart;
	logic refTick;
	logic modTick;
	logic updTick;
	logic [ctsc_pkg::NOTCH_W-1:0] updLast;

	// ************************************************************
	// filter reset causes
	// ************************************************************
	// sync input is already synchronous, so its edge is taken directly
	assign syncFall = st_r.syncPrev && !ctrl.syncN;
	assign restart = syncFall || ctrl.calCmd;

	// zero notch code would stall updates: treat it as one
	always_comb begin
		if (ctrl.notchCode == '0) begin
			updLast = '0;
		end else begin
			updLast = ctrl.notchCode - ctsc_pkg::NOTCH_W'(1);
		end
	end

	// ************************************************************
	// rate dividers
	// ************************************************************
	// the two sample dividers run free from the clock and restart only with the filter
	ctsc_div #(
		.W(ctsc_pkg::REF_W)
	) u_refDiv (
		.clk(core_clk),
		.srst(srst),
		.clr(restart),
		.en(1'b1),
		.lastCnt(ctsc_pkg::REF_W'(ctsc_pkg::REF_DIV - 1)),
		.tick(refTick)
	);

	ctsc_div #(
		.W(ctsc_pkg::MOD_W)
	) u_modDiv (
		.clk(core_clk),
		.srst(srst),
		.clr(restart),
		.en(1'b1),
		.lastCnt(ctsc_pkg::MOD_W'(ctsc_pkg::MOD_DIV - 1)),
		.tick(modTick)
	);

	// update period is notchCode modulator cycles
	ctsc_div #(
		.W(ctsc_pkg::NOTCH_W)
	) u_updDiv (
		.clk(core_clk),
		.srst(srst),
		.clr(restart),
		.en(modTick),
		.lastCnt(updLast),
		.tick(updTick)
	);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.syncPrev = ctrl.syncN;
		st_nxt.filterRst = restart;
		if (rdAck) begin
			st_nxt.result.ready = 1'b0;
		end
		unique case (st_r.mode)
			ctsc_pkg::CTSC_HOLD: begin
				// filter held while sync stays low
				if (ctrl.syncN) begin
					st_nxt.mode = ctsc_pkg::CTSC_SETTLE;
					if (st_r.calBusy) begin
						// calibration asked for during hold keeps its length
						st_nxt.settleLeft = ctsc_pkg::CAL_UPDATES;
					end else begin
						st_nxt.settleLeft = ctsc_pkg::SETTLE_UPDATES;
					end
				end
			end
			ctsc_pkg::CTSC_SETTLE: begin
				if (updTick) begin
					if (st_r.settleLeft <= ctsc_pkg::SETTLE_W'(1)) begin
						st_nxt.mode = ctsc_pkg::CTSC_RUN;
						st_nxt.settleLeft = '0;
						st_nxt.calBusy = 1'b0;
					end else begin
						st_nxt.settleLeft =
							st_r.settleLeft - ctsc_pkg::SETTLE_W'(1);
					end
				end
			end
			ctsc_pkg::CTSC_RUN: begin
				if (updTick) begin
					st_nxt.result.data = filtData;
					st_nxt.result.ready = 1'b1;
				end
			end
		endcase
		// a restart overrides everything above
		if (syncFall) begin
			st_nxt.mode = ctsc_pkg::CTSC_HOLD;
			st_nxt.settleLeft = ctsc_pkg::SETTLE_UPDATES;
			st_nxt.calBusy = 1'b0;
			st_nxt.result.ready = 1'b0;
		end else if (ctrl.calCmd) begin
			// a calibration under a low sync still waits in hold
			if (ctrl.syncN) begin
				st_nxt.mode = ctsc_pkg::CTSC_SETTLE;
			end else begin
				st_nxt.mode = ctsc_pkg::CTSC_HOLD;
			end
			st_nxt.settleLeft = ctsc_pkg::CAL_UPDATES;
			st_nxt.calBusy = 1'b1;
			st_nxt.result.ready = 1'b0;
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_r.mode <= ctsc_pkg::CTSC_SETTLE;
			st_r.syncPrev <= 1'b1;
			st_r.filterRst <= 1'b1;
			st_r.calBusy <= 1'b0;
			st_r.settleLeft <= ctsc_pkg::SETTLE_UPDATES;
			st_r.result.data <= ctsc_pkg::RESULT_RST;
			st_r.result.ready <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign refSampleEn = refTick;
	assign modSampleEn = modTick;
	assign updateEn = updTick && (st_r.mode == ctsc_pkg::CTSC_RUN);
	assign filterRst = st_r.filterRst;
	assign calBusy = st_r.calBusy;
	assign mode = st_r.mode;
	assign result = st_r.result;

endmodule
`default_nettype wire
